// ---- hw/isp_crc_pkg.sv ----
// Package: register indices, command codes and CRC constants for the ISP CRC block
package isp_crc_pkg;

  // ---------------------------------------------------------------------------
  // Register map (printed offsets are indices; byte address is four times)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_SLAVE_ADDR = 8'h0B;   // isp_slave_address, write only
  localparam logic [7:0]  IDX_ENABLE_KEY = 8'h0C;   // isp_enable_key, write only
  localparam logic [7:0]  IDX_STATUS     = 8'h0D;   // Block status, read only
  localparam logic [7:0]  IDX_CRC_VALUE  = 8'h0E;   // CRC remainder, read only
  localparam int          ADDR_W         = 8;
  localparam logic [1:0]  WORD_LSB       = 2'h0;    // Aligned word: low address bits

  // Status register fields
  localparam int          ST_ISP_EN      = 0;
  localparam int          ST_CRC_BUSY    = 1;
  localparam int          ST_TEST_A      = 2;
  localparam int          ST_TEST_B      = 3;
  localparam int          ST_WRITER      = 4;
  localparam int          ST_MODE_LSB    = 8;       // Data write mode, 3 bits

  // ---------------------------------------------------------------------------
  // Key, command codes and CRC constants
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  ENABLE_KEY     = 8'h93;
  localparam int          OPC_LSB        = 3;       // Command code lives in bits 7..3
  localparam logic [4:0]  OPC_PROGRAM    = 5'h14;   // 10100
  localparam logic [4:0]  OPC_ERASE      = 5'h06;   // 00110
  localparam logic [4:0]  OPC_BLANK      = 5'h0D;   // 01101
  localparam logic [4:0]  OPC_CLEAR_CRC  = 5'h1A;   // 11010
  localparam logic [4:0]  OPC_RESET_CPU  = 5'h09;   // 01001

  localparam logic [15:0] CRC_SEED       = 16'hFFFF;
  localparam int          CRC_BITS       = 8;       // Bit steps per counted byte
  localparam logic [2:0]  RD_BYTE_CMD    = 3'h2;    // Byte numbers of a command read
  localparam logic [2:0]  RD_BYTE_CRC_HI = 3'h5;
  localparam logic [2:0]  RD_BYTE_CRC_LO = 3'h6;

  // Data write mode selected by the last program, erase or blank command write
  typedef enum logic [2:0] {
    MODE_PROGRAM = 3'b001,
    MODE_ERASE   = 3'b010,
    MODE_BLANK   = 3'b100
  } wmode_e;

endpackage : isp_crc_pkg

// ---- hw/crc_bit_engine.sv ----
// Bit-serial CRC engine: folds one byte, most significant bit first, in eight cycles
`timescale 1ns/1ps
module crc_bit_engine (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        clearCrc,
  input  wire logic        foldStart,
  input  wire logic [7:0]  foldByte,
  output logic             crcBusy,
  output logic [15:0]      crcValue
);

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b01,
    ENG_SHIFT = 2'b10
  } eng_e;

  typedef struct packed {
    eng_e        state;
    logic [15:0] crc;
    logic [7:0]  shift;
    logic [2:0]  count;
  } eng_s;

  eng_s cur_q;
  eng_s nxt_d;
  logic crcFeedbackBit;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Clear wins over a byte in flight so a stale byte never lands after seeding
  always_comb begin
    nxt_d          = cur_q;
    crcFeedbackBit = cur_q.crc[15] ^ cur_q.shift[7];
    if (clearCrc) begin
      nxt_d.crc   = isp_crc_pkg::CRC_SEED;
      nxt_d.state = ENG_IDLE;
    end else begin
      unique case (cur_q.state)
        ENG_IDLE: begin
          if (foldStart) begin
            nxt_d.shift = foldByte;
            nxt_d.count = '0;
            nxt_d.state = ENG_SHIFT;
          end
        end
        ENG_SHIFT: begin
          nxt_d.crc   = {cur_q.crc[14] ^ crcFeedbackBit, cur_q.crc[13:2],
                         cur_q.crc[1] ^ crcFeedbackBit, cur_q.crc[0], crcFeedbackBit};
          nxt_d.shift = {cur_q.shift[6:0], 1'b0};  // Msb first
          nxt_d.count = cur_q.count + 3'h1;
          if (cur_q.count == 3'(isp_crc_pkg::CRC_BITS - 1)) begin
            nxt_d.state = ENG_IDLE;
          end
        end
        default: nxt_d.state = ENG_IDLE;
      endcase
    end
  end

  // State register; reset seeds the remainder
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur_q.state <= ENG_IDLE;
      cur_q.crc   <= isp_crc_pkg::CRC_SEED;
      cur_q.shift <= '0;
      cur_q.count <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign crcBusy  = (cur_q.state == ENG_SHIFT);
  assign crcValue = cur_q.crc;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_eight_steps;
    crcBusy [*8] ##1 !crcBusy;
  endsequence

  // A clear aborts the byte in flight, so it also abandons the step count
  a_fold_eight_steps: assert property (@(posedge sys_clk) disable iff (srst || clearCrc)
    (foldStart && !crcBusy) |=> s_eight_steps)
    else $error("Byte fold did not take exactly eight steps");
  a_reset_seed_value: assert property (@(posedge sys_clk)
    $past(srst) |-> crcValue == 16'hFFFF)
    else $error("CRC not seeded with all ones after reset");
  a_step_feedback_low: assert property (@(posedge sys_clk) disable iff (srst)
    (crcBusy && !clearCrc) |=> crcValue[0] == ($past(crcValue[15]) ^ $past(cur_q.shift[7])))
    else $error("CRC bit 0 does not take the feedback value");

endmodule : crc_bit_engine

// ---- hw/pin_mode_decode.sv ----
// Decode of test and writer modes from pin levels around the reset pin
`timescale 1ns/1ps
module pin_mode_decode (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic resetPin,
  input  wire logic dacOut9,
  input  wire logic dacOut8,
  input  wire logic selfTestOut,
  output logic      testModeA,
  output logic      testModeB,
  output logic      writerMode
);

  typedef struct packed {
    logic prevReset;
    logic modeA;
    logic modeB;
    logic writer;
  } pin_s;

  pin_s cur_q;
  pin_s nxt_d;

  // ---------------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------------
  // Mode B is caught on the falling edge and held until the pin rises again
  always_comb begin
    nxt_d           = cur_q;
    nxt_d.prevReset = resetPin;
    nxt_d.modeA     = resetPin & dacOut9 & ~dacOut8 & ~selfTestOut;
    nxt_d.writer    = resetPin & ~dacOut9 & dacOut8;
    if (cur_q.prevReset && !resetPin && dacOut9 && !dacOut8 && selfTestOut) begin
      nxt_d.modeB = 1'b1;
    end else if (resetPin) begin
      nxt_d.modeB = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    // Edge history loads the live pin level so a fall right after reset is neither lost nor invented
    if (srst) begin
      cur_q <= '{prevReset: resetPin, default: 1'b0};
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign testModeA  = cur_q.modeA;
  assign testModeB  = cur_q.modeB;
  assign writerMode = cur_q.writer;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_mode_a_levels: assert property (@(posedge sys_clk) disable iff (srst)
    (resetPin && dacOut9 && !dacOut8 && !selfTestOut) |=> testModeA)
    else $error("Test mode A not entered");
  a_mode_b_edge: assert property (@(posedge sys_clk) disable iff (srst)
    ($fell(resetPin) && dacOut9 && !dacOut8 && selfTestOut) |=> testModeB)
    else $error("Test mode B not entered on reset falling edge");
  a_writer_levels: assert property (@(posedge sys_clk) disable iff (srst)
    !$past(srst) |-> writerMode == $past(resetPin && !dacOut9 && dacOut8))
    else $error("Writer mode does not follow pin levels");

endmodule : pin_mode_decode

// ---- hw/isp_crc_and_mode_entry.sv ----
// ISP CRC checker, ISP enable registers, command decode and mode entry (top)
//
// Function
// - In a data write, each data byte that the ISP slave acknowledges is folded into the CRC.
// - The low address byte and the one dummy byte of an erase or blank are never folded.
// - The clear-CRC command loads all sixteen CRC bits with one.
// - Device reset seeds the CRC with FFFFh.
// - Bytes fold most significant bit first, feedback is CRC bit 15 XOR the data bit.
// - Each bit step shifts the CRC left, XORing feedback into bits 15 and 2 and into bit 0.
// - A command write with the reset-processor command restarts the processor.
// - ISP mode is enabled only by writing key 93h to the enable register at 0Ch.
// - Test mode A holds while reset, dac_out_9 high and dac_out_8, self_test_out low.
// - Test mode B is entered on reset falling with dac_out_9 high, dac_out_8 low, self_test_out high.
// - Writer mode holds while reset and dac_out_8 are high and dac_out_9 is low.
// - A command byte 11010xxx is the clear-CRC command.
// - A command read returns CRC high as its fifth byte and CRC low as its sixth.
// - A data byte refused because a program cycle is still running is not folded.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module isp_crc_and_mode_entry (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Command write bytes from the ISP slave
  input  wire logic        cmdByteValid,
  input  wire logic [7:0]  cmdByte,
  // Data write bytes from the ISP slave
  input  wire logic        dataByteValid,
  input  wire logic [7:0]  dataByte,
  input  wire logic        dataByteIsAddr,
  input  wire logic        progBusy,
  output logic             dataByteAck,
  // Command read byte selection
  input  wire logic        readByteReq,
  input  wire logic [2:0]  readByteNum,
  output logic [7:0]       readByteData,
  // Processor and ISP control
  output logic             ispEnable,
  output logic [7:0]       ispSlaveAddress,
  output logic             cpuResetReq,
  // Mode pins
  input  wire logic        resetPin,
  input  wire logic        dacOut9,
  input  wire logic        dacOut8,
  input  wire logic        selfTestOut,
  output logic             testModeA,
  output logic             testModeB,
  output logic             writerMode
);

  typedef struct packed {
    logic [7:0]            slaveAddr;
    logic                  isp_enable_key;
    isp_crc_pkg::wmode_e   mode;
    logic                  dummyTaken;
    logic [7:0]            lastCmd;
    logic [7:0]            readData;
    logic                  cpuReset;
    logic [31:0]           rdata;
    logic                  slvErr;
  } top_s;

  top_s cur_q;
  top_s nxt_d;

  logic        crcBusy;
  logic [15:0] crcValue;
  logic        clearCrc;
  logic        foldStart;
  logic        apbAccess;
  logic [5:0]  regIndex;
  logic        idxSlave;
  logic        idxKey;
  logic        idxStatus;
  logic        idxCrc;
  logic [4:0]  opcode;
  logic        eraseLike;
  logic [31:0] statusWord;

  // ---------------------------------------------------------------------------
  // Command decode and byte acceptance
  // ---------------------------------------------------------------------------
  // Opcode is the upper five bits; the low three are ignored
  assign opcode    = cmdByte[7:isp_crc_pkg::OPC_LSB];
  assign clearCrc  = cmdByteValid && (opcode == isp_crc_pkg::OPC_CLEAR_CRC);
  assign eraseLike = (cur_q.mode != isp_crc_pkg::MODE_PROGRAM);

  // A data byte is refused while the flash or the CRC engine is still busy
  assign dataByteAck = dataByteValid && !progBusy && !crcBusy;

  // Fold only acknowledged program data; address and erase dummy bytes are skipped
  assign foldStart = dataByteAck && !dataByteIsAddr && !eraseLike;

  crc_bit_engine u_crc (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .clearCrc  (clearCrc),
    .foldStart (foldStart),
    .foldByte  (dataByte),
    .crcBusy   (crcBusy),
    .crcValue  (crcValue)
  );

  pin_mode_decode u_pins (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .resetPin    (resetPin),
    .dacOut9     (dacOut9),
    .dacOut8     (dacOut8),
    .selfTestOut (selfTestOut),
    .testModeA   (testModeA),
    .testModeB   (testModeB),
    .writerMode  (writerMode)
  );

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  // Registers sit on aligned words; misaligned or unmapped addresses get an error
  assign apbAccess = psel && penable;
  assign regIndex  = paddr[7:2];
  assign idxSlave  = (paddr[1:0] == isp_crc_pkg::WORD_LSB) &&
                     (regIndex == isp_crc_pkg::IDX_SLAVE_ADDR[5:0]);
  assign idxKey    = (paddr[1:0] == isp_crc_pkg::WORD_LSB) &&
                     (regIndex == isp_crc_pkg::IDX_ENABLE_KEY[5:0]);
  assign idxStatus = (paddr[1:0] == isp_crc_pkg::WORD_LSB) &&
                     (regIndex == isp_crc_pkg::IDX_STATUS[5:0]);
  assign idxCrc    = (paddr[1:0] == isp_crc_pkg::WORD_LSB) &&
                     (regIndex == isp_crc_pkg::IDX_CRC_VALUE[5:0]);

  // Status word gathers the block's own live state
  always_comb begin
    statusWord                                  = '0;
    statusWord[isp_crc_pkg::ST_ISP_EN]          = cur_q.isp_enable_key;
    statusWord[isp_crc_pkg::ST_CRC_BUSY]        = crcBusy;
    statusWord[isp_crc_pkg::ST_TEST_A]          = testModeA;
    statusWord[isp_crc_pkg::ST_TEST_B]          = testModeB;
    statusWord[isp_crc_pkg::ST_WRITER]          = writerMode;
    statusWord[isp_crc_pkg::ST_MODE_LSB +: 3]   = cur_q.mode;
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Read data is captured in the setup cycle so it stands registered in access
  always_comb begin
    nxt_d          = cur_q;
    nxt_d.cpuReset = 1'b0;
    // Bus setup: latch read data and error for the access phase
    if (psel && !penable) begin
      nxt_d.slvErr = !(idxSlave || idxKey || idxStatus || idxCrc) ||
                     (!pwrite && (idxSlave || idxKey));
      if (!pwrite && idxStatus) begin
        nxt_d.rdata = statusWord;
      end else if (!pwrite && idxCrc) begin
        nxt_d.rdata = {16'h0000, crcValue};
      end else begin
        nxt_d.rdata = '0;  // Write-only registers read as zero
      end
    end
    // Register writes take effect at the access edge only
    if (apbAccess && pwrite && idxSlave) begin
      nxt_d.slaveAddr = pwdata[7:0];
    end
    if (apbAccess && pwrite && idxKey && pwdata[7:0] == isp_crc_pkg::ENABLE_KEY) begin
      nxt_d.isp_enable_key = 1'b1;
    end
    // Command write: select data write mode or act on a one-shot command
    if (cmdByteValid) begin
      nxt_d.lastCmd = cmdByte;
      unique case (opcode)
        isp_crc_pkg::OPC_PROGRAM: nxt_d.mode = isp_crc_pkg::MODE_PROGRAM;
        isp_crc_pkg::OPC_ERASE:   nxt_d.mode = isp_crc_pkg::MODE_ERASE;
        isp_crc_pkg::OPC_BLANK:   nxt_d.mode = isp_crc_pkg::MODE_BLANK;
        isp_crc_pkg::OPC_RESET_CPU: begin
          nxt_d.cpuReset = 1'b1;
          nxt_d.isp_enable_key    = 1'b0;  // Processor restarts from flash, ISP ends
        end
        default: ;
      endcase
    end
    // Dummy byte of erase and blank: noted, never folded
    if (dataByteAck && !dataByteIsAddr && eraseLike) begin
      nxt_d.dummyTaken = 1'b1;
    end else if (cmdByteValid) begin
      nxt_d.dummyTaken = 1'b0;
    end
    // Command read bytes; the CRC halves come fifth and sixth
    if (readByteReq) begin
      unique case (readByteNum)
        isp_crc_pkg::RD_BYTE_CMD:    nxt_d.readData = cur_q.lastCmd;
        isp_crc_pkg::RD_BYTE_CRC_HI: nxt_d.readData = crcValue[15:8];
        isp_crc_pkg::RD_BYTE_CRC_LO: nxt_d.readData = crcValue[7:0];
        default:                     nxt_d.readData = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur_q.slaveAddr  <= '0;
      cur_q.isp_enable_key      <= 1'b0;
      cur_q.mode       <= isp_crc_pkg::MODE_PROGRAM;
      cur_q.dummyTaken <= 1'b0;
      cur_q.lastCmd    <= '0;
      cur_q.readData   <= '0;
      cur_q.cpuReset   <= 1'b0;
      cur_q.rdata      <= '0;
      cur_q.slvErr     <= 1'b0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Zero wait states: every access ends in its first access cycle
  assign pready          = 1'b1;
  assign prdata          = cur_q.rdata;
  assign pslverr         = apbAccess && cur_q.slvErr;
  assign ispEnable       = cur_q.isp_enable_key;
  assign ispSlaveAddress = cur_q.slaveAddr;
  assign cpuResetReq     = cur_q.cpuReset;
  assign readByteData    = cur_q.readData;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_key_write;
    psel && penable && pwrite && idxKey && pwdata[7:0] == 8'h93;
  endsequence

  a_key_enables_isp: assert property (@(posedge sys_clk) disable iff (srst)
    s_key_write |=> ispEnable)
    else $error("Key write did not enable ISP");
  a_wrong_key_ignored: assert property (@(posedge sys_clk) disable iff (srst)
    (!ispEnable && !(apbAccess && pwrite && idxKey && pwdata[7:0] == 8'h93)) |=> !ispEnable)
    else $error("ISP enabled without the key");
  a_clear_loads_ones: assert property (@(posedge sys_clk) disable iff (srst)
    (cmdByteValid && cmdByte[7:3] == 5'h1A) |=> crcValue == 16'hFFFF)
    else $error("Clear command did not load all ones");
  a_busy_byte_refused: assert property (@(posedge sys_clk) disable iff (srst)
    (dataByteValid && progBusy) |-> !dataByteAck && !foldStart)
    else $error("Refused byte was acknowledged or folded");
  a_addr_not_folded: assert property (@(posedge sys_clk) disable iff (srst)
    (dataByteIsAddr || eraseLike) |-> !foldStart)
    else $error("Address or dummy byte folded");
  a_fold_blocks_ack: assert property (@(posedge sys_clk) disable iff (srst || clearCrc)
    (foldStart && !clearCrc) |=> !dataByteAck [*8])
    else $error("Data byte accepted during CRC steps");
  a_reset_cpu_pulse: assert property (@(posedge sys_clk) disable iff (srst)
    (cmdByteValid && cmdByte[7:3] == 5'h09) |=> cpuResetReq ##1 !cpuResetReq)
    else $error("Reset command gave no one-cycle restart");
  a_read_crc_high: assert property (@(posedge sys_clk) disable iff (srst)
    (readByteReq && readByteNum == 3'h5) |=> readByteData == $past(crcValue[15:8]))
    else $error("Fifth read byte is not CRC high half");

endmodule : isp_crc_and_mode_entry

// ---- testbench/isp_host_model.sv ----
// ISP host model: offers command and data bytes, fetches the CRC bytes
`timescale 1ns/1ps
module isp_host_model (
  input  wire logic       sys_clk,
  input  wire logic       dataByteAck,
  input  wire logic [7:0] readByteData,
  output logic            cmdByteValid,
  output logic [7:0]      cmdByte,
  output logic            dataByteValid,
  output logic [7:0]      dataByte,
  output logic            dataByteIsAddr,
  output logic            progBusy,
  output logic            readByteReq,
  output logic [2:0]      readByteNum
);
  // Idle bus at time zero
  initial begin
    cmdByteValid   = 1'b0;
    cmdByte        = 8'h00;
    dataByteValid  = 1'b0;
    dataByte       = 8'h00;
    dataByteIsAddr = 1'b0;
    progBusy       = 1'b0;
    readByteReq    = 1'b0;
    readByteNum    = 3'h0;
  end

  // One command byte; released lines show the inverse so stale data never matches
  task automatic send_cmd(input logic [7:0] b);
    @(posedge sys_clk);
    cmdByteValid <= 1'b1;
    cmdByte      <= b;
    @(posedge sys_clk);
    cmdByteValid <= 1'b0;
    cmdByte      <= ~b;
  endtask : send_cmd

  // Offer a data byte and hold it until acknowledged; a busy cycle stays refused
  task automatic send_data(input logic [7:0] b, input logic isAddr, input logic busy,
                           output logic acked);
    @(posedge sys_clk);
    dataByteValid  <= 1'b1;
    dataByte       <= b;
    dataByteIsAddr <= isAddr;
    progBusy       <= busy;
    acked = 1'b0;
    for (int i = 0; i < 20 && acked !== 1'b1; i++) begin
      @(posedge sys_clk);
      acked = dataByteAck;
    end
    dataByteValid <= 1'b0;
    dataByte      <= ~b;
    progBusy      <= 1'b0;
  endtask : send_data

  // Command read of bytes five and six: the CRC after a download
  task automatic read_crc(output logic [15:0] v);
    @(posedge sys_clk);
    readByteReq <= 1'b1;
    readByteNum <= 3'h5;
    @(posedge sys_clk);
    readByteNum <= 3'h6;
    @(posedge sys_clk);
    v[15:8] = readByteData;
    readByteReq <= 1'b0;
    @(posedge sys_clk);
    v[7:0] = readByteData;
  endtask : read_crc
endmodule : isp_host_model

// ---- testbench/isp_crc_and_mode_entry_tb.sv ----
// Testbench: APB registers, CRC folding, ISP commands and mode pins
`timescale 1ns/1ps
module isp_crc_and_mode_entry_tb;
  logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, cmdByte, dataByte, readByteData, ispSlaveAddress;
  logic [31:0] pwdata, prdata;
  logic        cmdByteValid, dataByteValid, dataByteIsAddr, progBusy, dataByteAck;
  logic        readByteReq, ispEnable, cpuResetReq, resetPin, dacOut9, dacOut8;
  logic        selfTestOut, testModeA, testModeB, writerMode;
  logic [2:0]  readByteNum;
  logic [31:0] rd;
  logic [15:0] crc;
  logic        err, ok;
  int          n_fail, check_count;

  isp_crc_and_mode_entry u_isp_crc_and_mode_entry (.*);
  isp_host_model         u_isp_host_model (.*);

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  // APB transfer: hold the request until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);  // A write lands at the access edge; callers look once it settled
  endtask : apb

  task automatic sc_registers();
    apb(8'h38, 1'b0, 32'h0);
    chk("crc after reset", 32'h0000FFFF, rd);
    apb(8'h2C, 1'b1, 32'h0000005A);
    chk("slave address", 32'h5A, {24'h0, ispSlaveAddress});
    apb(8'h30, 1'b1, 32'h00000092);
    chk("enable wrong key", 32'h0, {31'h0, ispEnable});
    apb(8'h30, 1'b1, 32'h00000093);
    chk("enable key", 32'h1, {31'h0, ispEnable});
    apb(8'h30, 1'b0, 32'h0);
    chk("read write-only", 32'h1, {31'h0, err});
    apb(8'h3C, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
  endtask : sc_registers

  // Address byte skipped, busy byte refused, back-to-back bytes folded in turn
  task automatic sc_fold();
    u_isp_host_model.send_data(8'h00, 1'b1, 1'b0, ok);
    chk("ack address byte", 32'h1, {31'h0, ok});
    u_isp_host_model.send_data(8'hF6, 1'b0, 1'b0, ok);
    chk("ack F6", 32'h1, {31'h0, ok});
    repeat (9) @(posedge sys_clk);
    u_isp_host_model.read_crc(crc);
    chk("crc F6", 32'hFF36, {16'h0, crc});
    u_isp_host_model.send_data(8'h55, 1'b0, 1'b1, ok);
    chk("busy refused", 32'h0, {31'h0, ok});
    u_isp_host_model.send_data(8'h28, 1'b0, 1'b0, ok);
    chk("ack 28", 32'h1, {31'h0, ok});
    u_isp_host_model.send_data(8'hC3, 1'b0, 1'b0, ok);
    chk("ack C3 after steps", 32'h1, {31'h0, ok});
    repeat (9) @(posedge sys_clk);
    apb(8'h38, 1'b0, 32'h0);
    chk("crc 28 C3", 32'h7031, rd);
  endtask : sc_fold

  // Erase byte not counted, clear-CRC, then reset-processor
  task automatic sc_commands();
    u_isp_host_model.send_cmd(8'h33);
    u_isp_host_model.send_data(8'hAB, 1'b0, 1'b0, ok);
    chk("erase dummy ack", 32'h1, {31'h0, ok});
    u_isp_host_model.send_cmd(8'h6B);
    u_isp_host_model.send_data(8'h5C, 1'b0, 1'b0, ok);
    chk("blank dummy ack", 32'h1, {31'h0, ok});
    repeat (9) @(posedge sys_clk);
    u_isp_host_model.read_crc(crc);
    chk("erase byte", 32'h7031, {16'h0, crc});
    u_isp_host_model.send_cmd(8'hD5);
    u_isp_host_model.read_crc(crc);
    chk("clear crc", 32'hFFFF, {16'h0, crc});
    u_isp_host_model.send_cmd(8'h4E);
    @(posedge sys_clk);
    chk("cpu reset pulse", 32'h1, {31'h0, cpuResetReq});
    @(posedge sys_clk);
    chk("cpu reset end", 32'h0, {31'h0, cpuResetReq});
    chk("isp off", 32'h0, {31'h0, ispEnable});
  endtask : sc_commands

  // Pin levels: A and writer while reset high, B on reset falling
  task automatic sc_modes();
    @(posedge sys_clk);
    resetPin <= 1'b1;
    dacOut8  <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("test mode A", 32'h1, {31'h0, testModeA});
    dacOut9 <= 1'b0;
    dacOut8 <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("writer mode", 32'h2, {30'h0, writerMode, testModeA});
    dacOut9     <= 1'b1;
    dacOut8     <= 1'b0;
    selfTestOut <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("no B yet", 32'h0, {31'h0, testModeB});
    resetPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("test mode B", 32'h1, {31'h0, testModeB});
    // Status: test mode B held, ISP off after the restart, blank mode selected
    apb(8'h34, 1'b0, 32'h0);
    chk("status word", 32'h00000408, rd);
    chk("status no error", 32'h0, {31'h0, err});
  endtask : sc_modes

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {resetPin, dacOut9, dacOut8, selfTestOut} = 4'hE;
    n_fail = 0;
    check_count = 0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    sc_registers();
    sc_fold();
    sc_commands();
    sc_modes();
    tally_and_finish();
  end
endmodule : isp_crc_and_mode_entry_tb
